// file: src/act_pkg.sv
package act_pkg;
  // register byte addresses; 16-bit values take offset (low) and offset+1 (high)
  localparam logic [7:0] ADDR_CUR_UPPER = 8'h60;
  localparam logic [7:0] ADDR_ACC_CLEAR = 8'h62;
  localparam logic [7:0] ADDR_CUR_LOWER = 8'h64;
  localparam logic [7:0] ADDR_PACK_THR = 8'h68;
  localparam logic [7:0] ADDR_CELL_THR = 8'h6C;
  localparam logic [7:0] ADDR_SHELF_THR = 8'h70;
  localparam logic [7:0] ADDR_HIGH_BYTE = 8'h01;

  // accumulator-clear bit positions
  localparam int CLR_CELL_TWO_TIME = 7;
  localparam int CLR_CELL_TWO_SUM = 6;
  localparam int CLR_TEMP_TIME = 5;
  localparam int CLR_TEMP_SUM = 4;
  localparam int CLR_CHARGE_TIME = 3;
  localparam int CLR_CHARGE_SUM = 2;
  localparam int CLR_DISCHARGE_TIME = 1;
  localparam int CLR_DISCHARGE_SUM = 0;

  // threshold-control enable bit positions
  localparam int EN_CURRENT_EXIT = 7;
  localparam int EN_CURRENT_ENTRY = 6;
  localparam int EN_PACK_EXIT = 5;
  localparam int EN_CELL_ONE_ENTRY = 4;
  localparam int EN_CELL_TWO_ENTRY = 3;
  localparam int EN_SHELF_ENTRY = 2;

  // result word layout
  localparam int SIGN_BIT = 15;
  localparam int MAG_W = 15;

  // reset values and the byte returned for unmapped reads
  localparam logic [15:0] THR_RESET = 16'h0000;
  localparam logic [7:0] CLR_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage

// file: src/act_regs.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RL1 - writing one clears the matching accumulator
// RL2 - clear bits return to zero by themselves
// RL3 - bits 7..4: cell-two time/sum, temperature time/sum
// RL4 - bits 3..0: charge time/sum, discharge time/sum
// RL5 - five thresholds: three voltage, two current
// RL6 - current thresholds compared with current result
// RL7 - voltage thresholds compared with pack/cell results
// RL8 - each comparison gated by its enable bit
// RL9 - thresholds stored left justified like results
// RL10 - compare magnitudes only, sign ignored
// RL11 - pin bit zero pulls pin low
// RL12 - result: sign bit 15, magnitude 14..0
// RL13 - current above upper threshold leaves sample-sleep
// RL14 - cleared accumulator reads zero next access
// RL15 - bits beyond resolution count as zero
module act_regs
  import act_pkg::*;
#(
  parameter int RES_W = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // register access from the two-wire interface engine
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // trip enables, resolution and measurement results
  input wire logic [7:0] threshold_control,
  input wire logic [RES_W-1:0] resolution,
  input wire logic [15:0] current_result,
  input wire logic [15:0] pack_voltage_result,
  input wire logic [15:0] cell_one_result,
  input wire logic [15:0] cell_two_result,
  // accumulator clear strobes
  output logic [7:0] accumulator_clear_pulse,
  // trip outcomes
  output logic current_exit_trip,
  output logic current_entry_trip,
  output logic pack_voltage_exit_trip,
  output logic cell_one_entry_trip,
  output logic cell_two_entry_trip,
  output logic shelf_entry_trip,
  // second general pin, open drain
  input wire logic general_pin_one_release,
  output logic general_pin_one_o,
  output logic general_pin_one_oe
);

  // refused at elaboration: the resolution cast below needs at least 4 bits
  if (RES_W < 4 || RES_W > 8) begin : g_res_check
    $error("act_regs: RES_W must lie in 4..8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // magnitude only, low bits past the resolution forced to zero
  function automatic logic [MAG_W-1:0] masked_mag(input logic [15:0] v, input logic [RES_W-1:0] res);
    logic [MAG_W-1:0] mask;
    mask = '1;
    if (res < RES_W'(MAG_W)) begin
      mask = ~(mask >> res); // [RL15]
    end
    return v[MAG_W-1:0] & mask; // [RL10] [RL12]
  endfunction

  // update one byte of a 16-bit threshold
  function automatic logic [15:0] put_byte(input logic [15:0] old, input logic hi, input logic [7:0] d);
    return hi ? {d, old[7:0]} : {old[15:8], d};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [15:0] cur_upper_reg, cur_upper_next;
  logic [15:0] cur_lower_reg, cur_lower_next;
  logic [15:0] pack_thr_reg, pack_thr_next;
  logic [15:0] cell_thr_reg, cell_thr_next;
  logic [15:0] shelf_thr_reg, shelf_thr_next;
  logic [7:0] clr_reg, clr_next;
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic [7:0] base;
  logic hi;

  always_comb begin
    base = {reg_addr[7:1], 1'b0};
    hi = reg_addr[0];
    cur_upper_next = cur_upper_reg;
    cur_lower_next = cur_lower_reg;
    pack_thr_next = pack_thr_reg;
    cell_thr_next = cell_thr_reg;
    shelf_thr_next = shelf_thr_reg;
    // strobe lasts one cycle, then the register reads zero again
    clr_next = CLR_RESET; // [RL2]
    if (reg_wr) begin
      case (base)
        ADDR_CUR_UPPER: cur_upper_next = put_byte(cur_upper_reg, hi, reg_wdata); // [RL5] [RL9]
        ADDR_CUR_LOWER: cur_lower_next = put_byte(cur_lower_reg, hi, reg_wdata); // [RL5] [RL9]
        ADDR_PACK_THR: pack_thr_next = put_byte(pack_thr_reg, hi, reg_wdata); // [RL5]
        ADDR_CELL_THR: cell_thr_next = put_byte(cell_thr_reg, hi, reg_wdata); // [RL5]
        ADDR_SHELF_THR: shelf_thr_next = put_byte(shelf_thr_reg, hi, reg_wdata); // [RL5]
        default: begin
        end
      endcase
      if (reg_addr == ADDR_ACC_CLEAR) begin
        clr_next = reg_wdata; // [RL1] [RL3] [RL4]
      end
    end
    rvalid_next = reg_rd;
    rdata_next = rdata_reg;
    if (reg_rd) begin
      case (base)
        ADDR_CUR_UPPER: rdata_next = hi ? cur_upper_reg[15:8] : cur_upper_reg[7:0];
        ADDR_CUR_LOWER: rdata_next = hi ? cur_lower_reg[15:8] : cur_lower_reg[7:0];
        ADDR_PACK_THR: rdata_next = hi ? pack_thr_reg[15:8] : pack_thr_reg[7:0];
        ADDR_CELL_THR: rdata_next = hi ? cell_thr_reg[15:8] : cell_thr_reg[7:0];
        ADDR_SHELF_THR: rdata_next = hi ? shelf_thr_reg[15:8] : shelf_thr_reg[7:0];
        default: rdata_next = UNMAPPED_READ;
      endcase
      if (reg_addr == ADDR_ACC_CLEAR) begin
        rdata_next = clr_reg;
      end else if (reg_addr == (ADDR_ACC_CLEAR | ADDR_HIGH_BYTE)) begin
        rdata_next = UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cur_upper_reg <= THR_RESET;
      cur_lower_reg <= THR_RESET;
      pack_thr_reg <= THR_RESET;
      cell_thr_reg <= THR_RESET;
      shelf_thr_reg <= THR_RESET;
      clr_reg <= CLR_RESET;
      rdata_reg <= RDATA_RESET;
      rvalid_reg <= 1'b0;
    end else begin
      cur_upper_reg <= cur_upper_next;
      cur_lower_reg <= cur_lower_next;
      pack_thr_reg <= pack_thr_next;
      cell_thr_reg <= cell_thr_next;
      shelf_thr_reg <= shelf_thr_next;
      clr_reg <= clr_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;
  // accumulators clear on this strobe, so the next access already sees zero
  assign accumulator_clear_pulse = clr_reg; // [RL14]

  ////////////////////////////////////////////////////////////////////////////
  // trip comparisons

  logic [5:0] trip_reg, trip_next;
  logic [MAG_W-1:0] m_cur, m_pack, m_c1, m_c2;

  always_comb begin
    m_cur = masked_mag(current_result, resolution);
    m_pack = masked_mag(pack_voltage_result, resolution);
    m_c1 = masked_mag(cell_one_result, resolution);
    m_c2 = masked_mag(cell_two_result, resolution);
    trip_next[5] = threshold_control[EN_CURRENT_EXIT]
                   && (m_cur > masked_mag(cur_upper_reg, resolution)); // [RL6] [RL8] [RL13]
    trip_next[4] = threshold_control[EN_CURRENT_ENTRY]
                   && (m_cur < masked_mag(cur_lower_reg, resolution)); // [RL6] [RL8]
    trip_next[3] = threshold_control[EN_PACK_EXIT]
                   && (m_pack > masked_mag(pack_thr_reg, resolution)); // [RL7] [RL8]
    trip_next[2] = threshold_control[EN_CELL_ONE_ENTRY]
                   && (m_c1 < masked_mag(cell_thr_reg, resolution)); // [RL7] [RL8]
    trip_next[1] = threshold_control[EN_CELL_TWO_ENTRY]
                   && (m_c2 < masked_mag(cell_thr_reg, resolution)); // [RL7] [RL8]
    trip_next[0] = threshold_control[EN_SHELF_ENTRY]
                   && (m_pack < masked_mag(shelf_thr_reg, resolution)); // [RL7] [RL8]
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      trip_reg <= 6'h00;
    end else begin
      trip_reg <= trip_next;
    end
  end

  assign {current_exit_trip, current_entry_trip, pack_voltage_exit_trip,
          cell_one_entry_trip, cell_two_entry_trip, shelf_entry_trip} = trip_reg;

  ////////////////////////////////////////////////////////////////////////////
  // open-drain pin: output level is always low, only the enable moves

  logic pin_oe_reg, pin_oe_next;
  logic pin_o_reg;

  always_comb begin
    pin_oe_next = !general_pin_one_release; // [RL11]
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pin_oe_reg <= 1'b0;
      pin_o_reg <= 1'b0;
    end else begin
      pin_oe_reg <= pin_oe_next;
      pin_o_reg <= 1'b0;
    end
  end

  assign general_pin_one_o = pin_o_reg;
  assign general_pin_one_oe = pin_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  logic wr_clr;
  assign wr_clr = reg_wr && (reg_addr == ADDR_ACC_CLEAR);

  a_clr_strobe_data: assert property (wr_clr |=> accumulator_clear_pulse == $past(reg_wdata)) // [RL1]
    else $error("clear strobe does not match written byte");
  a_clr_self_zero: assert property (!wr_clr |=> accumulator_clear_pulse == 8'h00) // [RL2]
    else $error("clear register did not return to zero");
  a_clr_upper_map: assert property (wr_clr && reg_wdata[CLR_CELL_TWO_TIME]
                                    |=> accumulator_clear_pulse[CLR_CELL_TWO_TIME] ##1
                                    !accumulator_clear_pulse[CLR_CELL_TWO_TIME] || $past(wr_clr)) // [RL3]
    else $error("cell-two time clear strobe wrong");
  a_clr_lower_map: assert property (wr_clr && reg_wdata[CLR_DISCHARGE_SUM]
                                    |=> accumulator_clear_pulse[CLR_DISCHARGE_SUM]) // [RL4]
    else $error("discharge sum clear strobe wrong");
  a_thr_store: assert property (reg_wr && reg_addr == (ADDR_PACK_THR | ADDR_HIGH_BYTE)
                                |=> pack_thr_reg[15:8] == $past(reg_wdata)) // [RL5]
    else $error("pack threshold high byte not stored");
  a_cur_exit_cmp: assert property (##1 current_exit_trip == $past(threshold_control[EN_CURRENT_EXIT]
                                   && masked_mag(current_result, resolution)
                                   > masked_mag(cur_upper_reg, resolution))) // [RL13]
    else $error("current exit trip wrong");
  a_shelf_cmp: assert property (##1 shelf_entry_trip == $past(threshold_control[EN_SHELF_ENTRY]
                                && pack_voltage_result[14:0] < shelf_thr_reg[14:0])
                                || $past(resolution) < RES_W'(MAG_W)) // [RL7]
    else $error("shelf trip wrong at full resolution");
  a_trip_gate: assert property (!threshold_control[EN_CURRENT_ENTRY] |=> !current_entry_trip) // [RL8]
    else $error("current entry trip without enable");
  a_sign_ignored: assert property ($changed(current_result[SIGN_BIT]) && $stable(current_result[14:0])
                                   && $stable(threshold_control) && $stable(resolution)
                                   && $stable(cur_upper_reg) |=> $stable(current_exit_trip)) // [RL10]
    else $error("sign bit changed trip outcome");
  a_pin_pull: assert property (##1 general_pin_one_oe == !$past(general_pin_one_release)
                               && !general_pin_one_o) // [RL11]
    else $error("open-drain pin control wrong");
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");

  c_clear_all: cover property (wr_clr && reg_wdata == 8'hFF);
  c_exit_trip: cover property (current_exit_trip);
  c_pull_down: cover property (general_pin_one_oe ##1 !general_pin_one_oe);
  c_read_clr: cover property (wr_clr ##1 reg_rd && reg_addr == ADDR_ACC_CLEAR);

endmodule // act_regs
`default_nettype wire

// file: tb/act_host.sv
`timescale 1ns/1ps
`default_nettype none
module act_host (
  // clock
  input wire logic mclk,
  // byte port toward the register block
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  // called at a falling edge; one idle edge first, so back-to-back calls never
  // drop and raise a strobe in the same time step; qualifiers scrambled once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    d = reg_rdata;
    v = reg_rvalid;
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask
endmodule // act_host
`default_nettype wire

// file: tb/act_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module act_regs_tb_top;
  import act_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, tc = 8'h00, clr, pat = 8'h00;
  logic reg_wr, reg_rd, reg_rvalid, rel = 1'b1, pin_o, pin_oe;
  logic [3:0] res = 4'hF;
  logic [15:0] cur = 16'h0000, pack = 16'h0000, c1 = 16'h0000, c2 = 16'h0000;
  wire logic [5:0] trips;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  always #5 mclk = ~mclk;
  act_host act_host_i (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  act_regs act_regs_i (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .threshold_control(tc), .resolution(res), .current_result(cur), .pack_voltage_result(pack),
    .cell_one_result(c1), .cell_two_result(c2), .accumulator_clear_pulse(clr),
    .current_exit_trip(trips[5]), .current_entry_trip(trips[4]), .pack_voltage_exit_trip(trips[3]),
    .cell_one_entry_trip(trips[2]), .cell_two_entry_trip(trips[1]), .shelf_entry_trip(trips[0]),
    .general_pin_one_release(rel), .general_pin_one_o(pin_o), .general_pin_one_oe(pin_oe));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    act_host_i.rd(a, d, v);
    chk({7'h00, v, d}, {8'h01, exp}, "read");
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    act_host_i.wr(a, d[7:0]);
    act_host_i.wr(a + ADDR_HIGH_BYTE, d[15:8]);
  endtask
  task automatic trip_case(input logic [3:0] r, input logic [7:0] t, input logic [15:0] i,
      input logic [15:0] p, input logic [15:0] a, input logic [15:0] b, input logic [5:0] exp);
    res = r;
    tc = t;
    cur = i;
    pack = p;
    c1 = a;
    c2 = b;
    repeat (2) @(negedge mclk);
    chk({10'h000, trips}, {10'h000, exp}, "trip outputs");
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ceiling well above the fewer than two hundred cycles the tests need
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  logic [7:0] addrs [5] = '{ADDR_CUR_UPPER, ADDR_CUR_LOWER, ADDR_PACK_THR, ADDR_CELL_THR, ADDR_SHELF_THR};
  initial begin
    repeat (16) @(negedge mclk);
    resetn = 1'b1;
    chk({8'h00, clr}, 16'h0000, "clear idle after reset");
    foreach (addrs[k]) begin
      rd_chk(addrs[k], 8'h00);
      rd_chk(addrs[k] + ADDR_HIGH_BYTE, 8'h00);
    end
    $display("test reset values done");
    foreach (addrs[k]) wr16(addrs[k], {8'hA0 + 8'(k), 8'h10 + 8'(k)});
    act_host_i.wr(8'h80, 8'hFF);
    foreach (addrs[k]) begin
      rd_chk(addrs[k], 8'h10 + 8'(k));
      rd_chk(addrs[k] + ADDR_HIGH_BYTE, 8'hA0 + 8'(k));
    end
    rd_chk(8'h80, UNMAPPED_READ);
    rd_chk(ADDR_ACC_CLEAR + 8'h01, UNMAPPED_READ);
    $display("test threshold access done");
    for (int b = 0; b < 9; b++) begin
      pat = (b == 8) ? 8'h81 : 8'h01 << b;
      act_host_i.wr(ADDR_ACC_CLEAR, pat);
      chk({8'h00, clr}, {8'h00, pat}, "clear strobe");
      @(negedge mclk);
      chk({8'h00, clr}, 16'h0000, "strobe ends");
      rd_chk(ADDR_ACC_CLEAR, 8'h00);
    end
    $display("test accumulator clear done");
    wr16(ADDR_CUR_UPPER, 16'h4000);
    wr16(ADDR_CUR_LOWER, 16'h2000);
    wr16(ADDR_PACK_THR, 16'h3000);
    wr16(ADDR_CELL_THR, 16'h2000);
    wr16(ADDR_SHELF_THR, 16'h1000);
    trip_case(4'hF, 8'hFC, 16'hC001, 16'h3800, 16'h1000, 16'h9000, 6'b101110);
    trip_case(4'hF, 8'hFC, 16'h4001, 16'h3800, 16'h1000, 16'h9000, 6'b101110);
    trip_case(4'h4, 8'hFC, 16'hC001, 16'h3800, 16'h1000, 16'h9000, 6'b001110);
    trip_case(4'hF, 8'h00, 16'hC001, 16'h3800, 16'h1000, 16'h9000, 6'b000000);
    trip_case(4'hF, 8'hFC, 16'h8100, 16'h0800, 16'h3000, 16'hB000, 6'b010001);
    trip_case(4'hF, 8'h84, 16'h8100, 16'h0800, 16'h3000, 16'hB000, 6'b000001);
    $display("test trip compare done");
    rel = 1'b0;
    repeat (2) @(negedge mclk);
    chk({14'h0000, pin_oe, pin_o}, 16'h0002, "pin pulled low");
    rel = 1'b1;
    repeat (2) @(negedge mclk);
    chk({14'h0000, pin_oe, pin_o}, 16'h0000, "pin released");
    $display("test pin pull-down done");
    print_verdict();
  end
endmodule // act_regs_tb_top
`default_nettype wire
